// >>> stp_pkg.sv
// package: register map, field layout and clock select codes for the timer prescaler
`default_nettype none

package stp_pkg;

    // ------------------------------------------------------------
    // register map (indices; byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] GTC_IDX = 8'h23;
    localparam logic [7:0] CSEL_IDX = 8'h24;
    localparam logic [7:0] STAT_IDX = 8'h25;
    localparam int unsigned ADDR_W = 10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned GTC_HOLD_BIT = 7;
    localparam int unsigned GTC_ASYNC_BIT = 1;
    localparam int unsigned GTC_SYNC_BIT = 0;
    localparam logic [7:0] GTC_RESET = 8'h00;
    localparam int unsigned CSEL_T0_LSB = 0;
    localparam int unsigned CSEL_T1_LSB = 4;
    localparam logic [2:0] CSEL_RESET = 3'h0;
    localparam int unsigned PSC_W = 10;
    localparam logic [PSC_W-1:0] PSC_RESET = 10'h000;

    // ------------------------------------------------------------
    // clock select codes
    // ------------------------------------------------------------
    localparam logic [2:0] CS_OFF = 3'h0;
    localparam logic [2:0] CS_DIRECT = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] stp_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    // timer tick selection, shared by both timers
    function automatic logic stp_tick(input logic [2:0] cs, input logic [3:0] tap,
                                      input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        case (cs)
            CS_OFF: t = 1'b0;
            CS_DIRECT: t = 1'b1;
            CS_DIV8: t = tap[0];
            CS_DIV64: t = tap[1];
            CS_DIV256: t = tap[2];
            CS_DIV1024: t = tap[3];
            CS_EXT_FALL: t = fall;
            CS_EXT_RISE: t = rise;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

endpackage

`default_nettype wire

// >>> stp_psc_if.sv
// interface: shared prescaler clear, tap pulses and count
`timescale 1ns/1ps
`default_nettype none

interface stp_psc_if;
    import stp_pkg::*;
    logic clr;
    logic [3:0] tap;
    logic [PSC_W-1:0] count;
    modport psc (input clr, output tap, output count);
    modport ctl (output clr, input tap, input count);
endinterface

`default_nettype wire

// >>> stp_prescaler.sv
// shared free running prescaler with four divided taps
`timescale 1ns/1ps
`default_nettype none

module stp_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    stp_psc_if.psc psc
);
    import stp_pkg::*;

    logic [PSC_W-1:0] cnt_r;
    logic [PSC_W-1:0] cnt_nxt;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // runs whatever the timers select; only a clear stops it
    assign cnt_nxt = psc.clr ? PSC_RESET : cnt_r + 10'h001;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= PSC_RESET;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // one pulse per wrap of the low bits: /8 /64 /256 /1024
    assign psc.tap[0] = ~psc.clr & (&cnt_r[2:0]);
    assign psc.tap[1] = ~psc.clr & (&cnt_r[5:0]);
    assign psc.tap[2] = ~psc.clr & (&cnt_r[7:0]);
    assign psc.tap[3] = ~psc.clr & (&cnt_r[9:0]);
    assign psc.count = cnt_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_tap8_period: assert property ((psc.tap[0] ##1 (!psc.clr)[*8]) |-> psc.tap[0])
        else $error("divide by 8 tap period wrong");
    a_free_run: assert property (!psc.clr |=> cnt_r == $past(cnt_r) + 10'h001)
        else $error("prescaler did not advance");
    a_clear_restart: assert property (psc.clr |=> cnt_r == PSC_RESET ##1 !psc.tap[0])
        else $error("prescaler clear did not restart taps");

endmodule // stp_prescaler

`default_nettype wire

// >>> stp_pin_sync.sv
// count pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none

module stp_pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic lat;
    logic s1_r;
    logic s2_r;
    logic prev_r;

    // ------------------------------------------------------------
    // sampling
    // ------------------------------------------------------------
    // latch open while clk is high, so the pin is held from the falling edge
    always_latch begin
        if (clk) begin
            lat = pin;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            s1_r <= lat;
            s2_r <= s1_r;
            prev_r <= s2_r;
        end
    end

    assign rise = s2_r & ~prev_r;
    assign fall = ~s2_r & prev_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_edge_delay: assert property ($rose(s1_r) |=> rise ##1 !rise)
        else $error("sampled rise not seen one cycle later");

endmodule // stp_pin_sync

`default_nettype wire

// >>> stp_timer_clk.sv
// shared timer prescaler and clock select with an apb register port
//
// Operation
// - select 1 gives a timer tick every system clock.
// - prescaler offers divide by 8, 64, 256 and 1024 taps.
// - prescaler runs freely, one instance serves both timers.
// - first divided tick comes 1 to N+1 cycles after enabling.
// - prescaler reset restarts divided timing for both timers.
// - count pins sampled every clock, then edge detected.
// - sampling uses a clock-high latch then rising edge flops.
// - select 7 ticks on rising edges, select 6 on falling edges.
// - pin edge to counter update takes 2.5 to 3.5 clocks.
// - external ticks pass undivided, never through the prescaler.
// - hold mode bit keeps both reset bits, holding prescalers.
// - clearing hold mode clears both reset bits in hardware.
// - writing reset bit one resets prescaler, cleared unless holding.
// - pin edges count even when the pin drives as output.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module stp_timer_clk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [stp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    output logic timer_zero_tick,
    output logic timer_one_tick,
    output logic async_prescaler_reset
);
    import stp_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    logic rstn;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign rstn = rst_sync_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic acc;
    logic fin;
    logic hit_gtc;
    logic hit_csel;
    logic hit_stat;
    logic hit_any;
    logic wr_gtc;
    logic wr_csel;
    logic [31:0] rd_word;

    assign acc = psel & penable;
    // one wait state: pready rises in the second access cycle
    assign fin = acc & pready_r;
    assign hit_gtc = paddr == stp_addr(GTC_IDX);
    assign hit_csel = paddr == stp_addr(CSEL_IDX);
    assign hit_stat = paddr == stp_addr(STAT_IDX);
    assign hit_any = hit_gtc | hit_csel | hit_stat;
    assign wr_gtc = fin & pwrite & hit_gtc;
    assign wr_csel = fin & pwrite & hit_csel;

    // ------------------------------------------------------------
    // general timer control
    // ------------------------------------------------------------
    logic hold_r;
    logic sync_r;
    logic async_r;
    logic hold_nxt;
    logic sync_nxt;
    logic async_nxt;

    assign hold_nxt = wr_gtc ? pwdata[GTC_HOLD_BIT] : hold_r;
    // written value kept while holding, dropped the next cycle otherwise
    assign sync_nxt = wr_gtc ? pwdata[GTC_SYNC_BIT] : (hold_r & sync_r);
    assign async_nxt = wr_gtc ? pwdata[GTC_ASYNC_BIT] : (hold_r & async_r);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= GTC_RESET[GTC_HOLD_BIT];
            sync_r <= GTC_RESET[GTC_SYNC_BIT];
            async_r <= GTC_RESET[GTC_ASYNC_BIT];
        end else begin
            hold_r <= hold_nxt;
            sync_r <= sync_nxt;
            async_r <= async_nxt;
        end
    end

    // ------------------------------------------------------------
    // clock select
    // ------------------------------------------------------------
    logic [2:0] cs0_r;
    logic [2:0] cs1_r;
    logic div0;
    logic div1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs0_r <= CSEL_RESET;
            cs1_r <= CSEL_RESET;
        end else if (wr_csel) begin
            cs0_r <= pwdata[CSEL_T0_LSB +: 3];
            cs1_r <= pwdata[CSEL_T1_LSB +: 3];
        end
    end

    // only the divided selects are muted by a prescaler clear
    function automatic logic stp_is_div(input logic [2:0] cs);
        return (cs >= CS_DIV8) && (cs <= CS_DIV1024);
    endfunction

    assign div0 = stp_is_div(cs0_r);
    assign div1 = stp_is_div(cs1_r);

    // ------------------------------------------------------------
    // shared prescaler and pin edges
    // ------------------------------------------------------------
    stp_psc_if psc ();
    logic rise0;
    logic fall0;
    logic rise1;
    logic fall1;

    // one clear for both timers; a resync of one shifts the other too
    assign psc.clr = sync_r;

    stp_prescaler u_psc (
        .clk(clk),
        .rst_n(rstn),
        .psc(psc.psc)
    );

    // pin read with no regard to pin direction
    stp_pin_sync u_pin0 (
        .clk(clk),
        .rst_n(rstn),
        .pin(count_pin_zero),
        .rise(rise0),
        .fall(fall0)
    );

    stp_pin_sync u_pin1 (
        .clk(clk),
        .rst_n(rstn),
        .pin(count_pin_one),
        .rise(rise1),
        .fall(fall1)
    );

    // ------------------------------------------------------------
    // tick outputs
    // ------------------------------------------------------------
    logic t0_nxt;
    logic t1_nxt;
    logic t0_tick_r;
    logic t1_tick_r;

    // taps are not restarted on a select change, hence the 1..N+1 lag
    assign t0_nxt = stp_tick(cs0_r, psc.tap, rise0, fall0);
    assign t1_nxt = stp_tick(cs1_r, psc.tap, rise1, fall1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            t0_tick_r <= 1'b0;
            t1_tick_r <= 1'b0;
        end else begin
            t0_tick_r <= t0_nxt;
            t1_tick_r <= t1_nxt;
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    assign rd_word = hit_gtc ? {24'h000000, hold_r, 5'h00, async_r, sync_r} :
                     hit_csel ? {24'h000000, 1'b0, cs1_r, 1'b0, cs0_r} :
                     hit_stat ? {22'h0, psc.count} : 32'h00000000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~hit_any;
            prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_word : 32'h00000000;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign timer_zero_tick = t0_tick_r;
    assign timer_one_tick = t1_tick_r;
    assign async_prescaler_reset = async_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_direct_every_clock: assert property (cs0_r == CS_DIRECT |=> timer_zero_tick)
        else $error("direct select did not tick");
    a_off_no_tick: assert property (cs1_r == CS_OFF |=> !timer_one_tick)
        else $error("tick while clock select is off");
    a_ext_rise_tick: assert property (cs0_r == CS_EXT_RISE && rise0 |=> timer_zero_tick)
        else $error("rising pin edge lost");
    a_ext_fall_only: assert property (cs1_r == CS_EXT_FALL && !fall1 |=> !timer_one_tick)
        else $error("falling mode ticked without a falling edge");
    a_hold_keeps_bits: assert property (hold_r && !wr_gtc |=> $stable(sync_r) && $stable(async_r))
        else $error("reset bits changed while holding");
    a_release_clears: assert property (!hold_r && !wr_gtc |=> !sync_r && !async_r)
        else $error("reset bits not cleared out of hold");
    a_sync_pulse: assert property (wr_gtc && pwdata[0] && !pwdata[7] |=> sync_r ##1 !sync_r)
        else $error("prescaler reset was not a single pulse");
    a_div8_tick: assert property (cs0_r == CS_DIV8 && psc.tap[0] |=> timer_zero_tick)
        else $error("divide by 8 tap not passed to timer");

    // ------------------------------------------------------------
    // checks: tick selection and the shared clear
    // ------------------------------------------------------------
    a_direct_t1: assert property (cs1_r == CS_DIRECT |=> timer_one_tick)
        else $error("direct select did not tick timer one");
    a_off_t0: assert property (cs0_r == CS_OFF |=> !timer_zero_tick)
        else $error("timer zero ticked while off");
    a_ext_fall_tick: assert property (cs1_r == CS_EXT_FALL && fall1 |=> timer_one_tick)
        else $error("falling pin edge lost");
    a_ext_rise_only: assert property (cs0_r == CS_EXT_RISE && !rise0 |=> !timer_zero_tick)
        else $error("rising mode ticked without a rising edge");
    a_div8_t1: assert property (cs1_r == CS_DIV8 && psc.tap[0] |=> timer_one_tick)
        else $error("divide by 8 tap not passed to timer one");
    a_div64_t1: assert property (cs1_r == CS_DIV64 |=> timer_one_tick == $past(psc.tap[1]))
        else $error("timer one does not follow the divide by 64 tap");
    a_div64_t0: assert property (cs0_r == CS_DIV64 |=> timer_zero_tick == $past(psc.tap[1]))
        else $error("select 3 does not follow the divide by 64 tap");
    a_div256_t0: assert property (cs0_r == CS_DIV256 |=> timer_zero_tick == $past(psc.tap[2]))
        else $error("select 4 does not follow the divide by 256 tap");
    a_div1024_t0: assert property (cs0_r == CS_DIV1024 |=> timer_zero_tick == $past(psc.tap[3]))
        else $error("select 5 does not follow the divide by 1024 tap");
    a_clear_mutes_t0: assert property (sync_r && div0 |=> !timer_zero_tick)
        else $error("divided tick of timer zero during prescaler clear");
    a_clear_mutes_t1: assert property (sync_r && div1 |=> !timer_one_tick)
        else $error("divided tick of timer one during prescaler clear");

    // ------------------------------------------------------------
    // checks: control register and prescaler restart
    // ------------------------------------------------------------
    a_hold_halts: assert property (hold_r && sync_r |=> psc.count == PSC_RESET)
        else $error("prescaler ran while held in reset");
    a_release_restart: assert property ($fell(hold_r) && $past(sync_r) && !sync_r |->
                                        psc.count == PSC_RESET ##1 psc.count != PSC_RESET)
        else $error("prescaler did not restart on leaving hold");
    a_sync_restart: assert property (wr_gtc && pwdata[GTC_SYNC_BIT] |-> ##2 psc.count == PSC_RESET)
        else $error("prescaler reset bit did not clear the prescaler");
    a_taps_nested: assert property (psc.tap[3] |-> psc.tap[2] && psc.tap[1] && psc.tap[0])
        else $error("taps do not come from one shared counter");

    // ------------------------------------------------------------
    // checks: register bus answer
    // ------------------------------------------------------------
    // every answer is registered, so it stands exactly one cycle
    a_ready_follows: assert property (psel && penable && !pready |=> pready)
        else $error("no ready one cycle into the access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside a read answer");
    a_unmapped_err: assert property (psel && penable && !pready && !hit_any |=> pslverr)
        else $error("unmapped access not flagged");
    a_stat_no_err: assert property (psel && penable && !pready && hit_stat |=> !pslverr)
        else $error("status access flagged as an error");

endmodule // stp_timer_clk

`default_nettype wire

// >>> stp_ext_src.sv
// external count source model driving one timer count pin
`timescale 1ns/1ps
`default_nettype none

module stp_ext_src (
    input wire logic clk,
    input wire logic en,
    input wire logic [7:0] half,
    output logic pin
);
    logic [7:0] cnt_r;

    initial pin = 1'b0;
    initial cnt_r = 8'h00;

    // ------------------------------------------------------------
    // square wave, changed just after a rising edge
    // ------------------------------------------------------------
    // the level is held between bursts, so the select can be changed on a quiet pin
    always @(posedge clk) begin
        if (en) begin
            if (cnt_r + 8'h01 >= half) begin
                cnt_r <= 8'h00;
                pin <= ~pin;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule // stp_ext_src

`default_nettype wire

// >>> testbench.sv
// self-checking bench for the shared timer prescaler
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import stp_pkg::*;
    localparam logic [ADDR_W-1:0] A_GTC = {GTC_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_CSEL = {CSEL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {STAT_IDX, 2'b00};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tick0, tick1, apr, pin0, pin1;
    logic src_en = 1'b0;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    stp_timer_clk dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_pin_zero(pin0), .count_pin_one(pin1), .timer_zero_tick(tick0),
        .timer_one_tick(tick1), .async_prescaler_reset(apr));
    stp_ext_src src0 (.clk(clk), .en(src_en), .half(8'h03), .pin(pin0));
    stp_ext_src src1 (.clk(clk), .en(src_en), .half(8'h04), .pin(pin1));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ticks are one-cycle pulses, so they are counted at the falling edge
    task automatic count(input int cycles, output int c0, output int c1);
        c0 = 0;
        c1 = 0;
        repeat (cycles) begin
            @(negedge clk);
            c0 += int'(tick0 === 1'b1);
            c1 += int'(tick1 === 1'b1);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, A_GTC, 32'h0);
        chk("control reset", 32'h0, rd);
        apb(1'b1, A_GTC, 32'h7c);
        apb(1'b0, A_GTC, 32'h0);
        chk("reserved bits", 32'h0, rd);
        apb(1'b0, 10'h000, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, A_GTC, 32'h01);
        apb(1'b0, A_GTC, 32'h0);
        chk("sync reset self clear", 32'h0, rd);
        apb(1'b1, A_GTC, 32'h82);
        repeat (3) @(negedge clk);
        chk("async bit held", 32'h1, {31'h0, apr});
        // hold off with the async bit written one: hardware must drop it
        apb(1'b1, A_GTC, 32'h02);
        repeat (2) @(negedge clk);
        chk("async bit cleared", 32'h0, {31'h0, apr});
        $display("test regs done");
    endtask

    task automatic t_direct();
        int c0, c1;
        apb(1'b1, A_CSEL, 32'h11);
        repeat (2) @(negedge clk);
        count(20, c0, c1);
        chk("direct t0", 32'd20, 32'(c0));
        chk("direct t1", 32'd20, 32'(c1));
        apb(1'b1, A_CSEL, 32'h00);
        repeat (2) @(negedge clk);
        count(40, c0, c1);
        chk("off ticks", 32'd0, 32'(c0 + c1));
        $display("test direct done");
    endtask

    // timer 1 stays on the /8 tap while timer 0 walks all taps
    task automatic t_div();
        int dv[4] = '{8, 64, 256, 1024};
        int c0, c1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, A_CSEL, {25'h0, CS_DIV8, 1'b0, CS_DIV8 + 3'(k)});
            repeat (2) @(negedge clk);
            count(2048, c0, c1);
            chk("tap t0", 32'(2048 / dv[k]), 32'(c0));
            chk("tap t1", 32'd256, 32'(c1));
        end
        $display("test div done");
    endtask

    task automatic t_sync();
        int c0, c1, f0, f1;
        f0 = 0;
        f1 = 0;
        apb(1'b1, A_CSEL, {25'h0, CS_DIV64, 1'b0, CS_DIV8});
        apb(1'b1, A_GTC, 32'h81);
        repeat (2) @(negedge clk);
        count(300, c0, c1);
        chk("held ticks", 32'd0, 32'(c0 + c1));
        apb(1'b0, A_STAT, 32'h0);
        chk("held count", 32'h0, rd);
        apb(1'b0, A_GTC, 32'h0);
        chk("held control", 32'h81, rd);
        apb(1'b1, A_GTC, 32'h00);
        for (int i = 1; i < 200 && f1 == 0; i++) begin
            @(negedge clk);
            if (tick0 === 1'b1 && f0 == 0) f0 = i;
            if (tick1 === 1'b1) f1 = i;
        end
        chk("first tick in range", 32'h1, {31'h0, f0 >= 1 && f0 <= 9});
        chk("taps restart together", 32'd56, 32'(f1 - f0));
        apb(1'b0, A_GTC, 32'h0);
        chk("control after release", 32'h0, rd);
        $display("test sync done");
    endtask

    task automatic t_ext();
        int c0, c1, n;
        apb(1'b1, A_CSEL, {25'h0, CS_EXT_FALL, 1'b0, CS_EXT_RISE});
        repeat (2) @(posedge clk);
        src_en <= 1'b1;
        n = 0;
        for (int i = 0; i < 20 && pin0 !== 1'b1; i++) @(negedge clk);
        while (tick0 !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk("pin to tick", 32'd3, 32'(n));
        count(120, c0, c1);
        chk("rising ticks", 32'd20, 32'(c0));
        chk("falling ticks", 32'd15, 32'(c1));
        @(posedge clk);
        src_en <= 1'b0;
        $display("test ext done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_direct();
        t_div();
        t_sync();
        t_ext();
        conclude();
    end
endmodule // testbench

`default_nettype wire
